// *** logic/awc_pkg.sv ***
// shared constants and types of the adc window comparator
package awc_pkg;
    // ========================================================
    // data word layout
    localparam int DATA_W = 16;
    localparam int RES_W = 10;
    localparam int PAD_W = DATA_W - RES_W;
    localparam int BYTE_W = 8;
    localparam logic [PAD_W-1:0] PAD_ZERO = 6'h00;
    localparam logic [DATA_W-1:0] WORD_RST = 16'h0000;
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

    // ========================================================
    // timing
    localparam int SYS_CLK_KHZ = 100000;
    localparam int SAR_CLK_MAX_KHZ = 2500;
    // least divider, rounded up so the sar clock never exceeds its limit
    localparam int SAR_DIV = (SYS_CLK_KHZ + SAR_CLK_MAX_KHZ - 1)
                             / SAR_CLK_MAX_KHZ;
    localparam int CONV_SAR_CLKS = 16;
    localparam int DIV_W = 8;
    localparam int BIT_W = 5;

    // ========================================================
    // carriers and states
    typedef struct packed {
        logic wr;
        logic sel_below;
        logic high;
        logic [BYTE_W-1:0] data;
    } awc_lim_wr_t;

    typedef enum logic {AWC_IDLE, AWC_CONV} awc_state_t;
endpackage

// *** logic/awc_limit_reg.sv ***
// one 16-bit limit word built from a high and a low byte register
`timescale 1ns/10ps
`default_nettype none
module awc_limit_reg #(
    parameter int BYTE_W = awc_pkg::BYTE_W
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // byte writes
    input wire logic wr_high_i,
    input wire logic wr_low_i,
    input wire logic [BYTE_W-1:0] data_i,
    // limit word
    output logic [2*BYTE_W-1:0] word_o
);
    logic [BYTE_W-1:0] high_byte;
    logic [BYTE_W-1:0] low_byte;

    // =========================================================
    // byte registers, written independently
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            high_byte <= awc_pkg::BYTE_RST;
            low_byte <= awc_pkg::BYTE_RST;
        end else begin
            if (wr_high_i) begin
                high_byte <= data_i;
            end
            if (wr_low_i) begin
                low_byte <= data_i;
            end
        end
    end

    assign word_o = {high_byte, low_byte};
endmodule // awc_limit_reg
`default_nettype wire

// *** logic/awc_top.sv ***
// adc window comparator: conversion timing, data word and window flag
`timescale 1ns/10ps
`default_nettype none
module awc_top #(
    parameter int SAR_DIV = awc_pkg::SAR_DIV,
    parameter int CONV_SAR_CLKS = awc_pkg::CONV_SAR_CLKS
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // conversion control
    input wire logic start_i,
    input wire logic left_justify_select_i,
    input wire logic differential_i,
    input wire logic [awc_pkg::RES_W-1:0] result_i,
    // limit byte writes and flag clear
    input wire awc_pkg::awc_lim_wr_t lim_wr_i,
    input wire logic window_match_flag_clr_i,
    // status and data
    output logic busy_o,
    output logic conv_done_o,
    output logic [awc_pkg::DATA_W-1:0] data_word_o,
    output logic window_match_flag_o
);
    localparam int DW = awc_pkg::DATA_W;
    localparam logic [awc_pkg::DIV_W-1:0] DIV_LAST =
        awc_pkg::DIV_W'(SAR_DIV - 1);
    localparam logic [awc_pkg::BIT_W-1:0] BIT_LAST =
        awc_pkg::BIT_W'(CONV_SAR_CLKS - 1);
    localparam logic [awc_pkg::DIV_W-1:0] DIV_ZERO = 8'h00;
    localparam logic [awc_pkg::BIT_W-1:0] BIT_ZERO = 5'h00;

    // =========================================================
    // helpers
    // strict less-than, signed for differential data
    function automatic logic lt_f(input logic [DW-1:0] a,
                                  input logic [DW-1:0] b,
                                  input logic sgn);
        lt_f = sgn ? ($signed(a) < $signed(b)) : (a < b);
    endfunction

    // place the raw result as the justification asks
    function automatic logic [DW-1:0] fmt_f(
        input logic [awc_pkg::RES_W-1:0] res,
        input logic lj,
        input logic diff);
        if (lj) begin
            fmt_f = {res, awc_pkg::PAD_ZERO};
        end else if (diff) begin
            fmt_f = {{awc_pkg::PAD_W{res[awc_pkg::RES_W-1]}}, res};
        end else begin
            fmt_f = {awc_pkg::PAD_ZERO, res};
        end
    endfunction

    // =========================================================
    // limit registers
    logic [DW-1:0] below_limit;
    logic [DW-1:0] above_limit;
    wire wr_below = lim_wr_i.wr & lim_wr_i.sel_below;
    wire wr_above = lim_wr_i.wr & ~lim_wr_i.sel_below;

    awc_limit_reg u_below (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .wr_high_i(wr_below & lim_wr_i.high),
        .wr_low_i(wr_below & ~lim_wr_i.high),
        .data_i(lim_wr_i.data),
        .word_o(below_limit)
    );

    awc_limit_reg u_above (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .wr_high_i(wr_above & lim_wr_i.high),
        .wr_low_i(wr_above & ~lim_wr_i.high),
        .data_i(lim_wr_i.data),
        .word_o(above_limit)
    );

    // =========================================================
    // conversion sequencer
    awc_pkg::awc_state_t state;
    awc_pkg::awc_state_t next_state;
    logic [awc_pkg::DIV_W-1:0] div_cnt;
    logic [awc_pkg::BIT_W-1:0] bit_cnt;

    // divider restarts with each conversion so the length is exact
    wire in_conv = (state == awc_pkg::AWC_CONV);
    wire sar_tick = in_conv & (div_cnt == DIV_LAST);
    wire eval = sar_tick & (bit_cnt == BIT_LAST);
    wire take_start = start_i & ~in_conv;

    always_comb begin
        next_state = state;
        unique case (state)
            awc_pkg::AWC_IDLE: begin
                if (start_i) begin
                    next_state = awc_pkg::AWC_CONV;
                end
            end
            awc_pkg::AWC_CONV: begin
                if (eval) begin
                    next_state = awc_pkg::AWC_IDLE;
                end
            end
        endcase
    end

    // divider and sar period counter
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= awc_pkg::AWC_IDLE;
            div_cnt <= DIV_ZERO;
            bit_cnt <= BIT_ZERO;
        end else begin
            state <= next_state;
            if (take_start || sar_tick) begin
                div_cnt <= DIV_ZERO;
            end else if (in_conv) begin
                div_cnt <= div_cnt + 1'b1;
            end
            if (take_start) begin
                bit_cnt <= BIT_ZERO;
            end else if (sar_tick) begin
                bit_cnt <= bit_cnt + 1'b1;
            end
        end
    end

    // =========================================================
    // window decision on the word being latched now
    wire [DW-1:0] next_word = fmt_f(result_i, left_justify_select_i,
                                    differential_i);
    wire cmp_below = lt_f(next_word, below_limit, differential_i);
    wire cmp_above = lt_f(above_limit, next_word, differential_i);
    wire lt_over_gt = lt_f(above_limit, below_limit, differential_i);
    // inside window when limits are ordered high/low, outside otherwise
    wire win_hit = lt_over_gt ? (cmp_below & cmp_above)
                              : (cmp_below | cmp_above);
    wire next_flag = (eval & win_hit) ? 1'b1
                   : (window_match_flag_clr_i ? 1'b0 : window_match_flag_o);

    // outputs; a hit in the clearing cycle wins over the clear
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_o <= 1'b0;
            conv_done_o <= 1'b0;
            data_word_o <= awc_pkg::WORD_RST;
            window_match_flag_o <= 1'b0;
        end else begin
            busy_o <= (next_state == awc_pkg::AWC_CONV);
            conv_done_o <= eval;
            if (eval) begin
                data_word_o <= next_word;
            end
            window_match_flag_o <= next_flag;
        end
    end

    // =========================================================
    // checks
    int unsigned busy_cycles;
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_cycles <= 0;
        end else if (!busy_o) begin
            busy_cycles <= 0;
        end else begin
            busy_cycles <= busy_cycles + 1;
        end
    end

    property p_inside;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (eval && lt_over_gt && cmp_below && cmp_above)
            |=> window_match_flag_o;
    endproperty
    a_inside: assert property (p_inside)
        else $error("inside window hit did not set flag");

    property p_outside;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (eval && !lt_over_gt && !window_match_flag_o
         && !window_match_flag_clr_i && !cmp_below && !cmp_above)
            |=> !window_match_flag_o;
    endproperty
    a_outside: assert property (p_outside)
        else $error("flag set with result inside outside-mode limits");

    property p_signed;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (differential_i && next_word[DW-1] && !above_limit[DW-1])
            |-> !cmp_above;
    endproperty
    a_signed: assert property (p_signed)
        else $error("negative word judged above positive limit");

    property p_left;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (eval && left_justify_select_i)
            |=> data_word_o == {$past(result_i), awc_pkg::PAD_ZERO};
    endproperty
    a_left: assert property (p_left)
        else $error("left justified word misplaced");

    property p_length;
        @(posedge core_clk_i) disable iff (!nrst_i)
        $fell(busy_o) |-> busy_cycles == SAR_DIV * CONV_SAR_CLKS;
    endproperty
    a_length: assert property (p_length)
        else $error("conversion length wrong");

    property p_sticky;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (window_match_flag_o && !window_match_flag_clr_i)
            |=> window_match_flag_o;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag dropped without a clear");

    property p_limit;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (wr_below && lim_wr_i.high)
            |=> below_limit[DW-1 -: awc_pkg::BYTE_W] == $past(lim_wr_i.data);
    endproperty
    a_limit: assert property (p_limit)
        else $error("below limit high byte not written");

    property p_right;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (eval && !left_justify_select_i)
            |=> data_word_o[DW-1:awc_pkg::RES_W] ==
                ($past(differential_i) ?
                 {awc_pkg::PAD_W{data_word_o[awc_pkg::RES_W-1]}}
                 : awc_pkg::PAD_ZERO);
    endproperty
    a_right: assert property (p_right)
        else $error("right justified top bits wrong");

    property p_same;
        @(posedge core_clk_i) disable iff (!nrst_i)
        $rose(conv_done_o) |-> (window_match_flag_o ||
            !$past(win_hit)) && !busy_o;
    endproperty
    a_same: assert property (p_same)
        else $error("window flag not set with conversion complete");
endmodule // awc_top
`default_nettype wire

// *** dv/adc_window_comparator_tb_top.sv ***
// self-checking bench of the adc window comparator
`timescale 1ns/10ps
`default_nettype none
module adc_window_comparator_tb_top;
    // short sar divider keeps each conversion at 32 cycles
    localparam int DIV = 2;
    localparam int CLKS = 16;
    localparam int LIMIT = 20000;
    logic core_clk_i;
    logic nrst_i;
    logic start_i;
    logic lj;
    logic diff;
    logic clr;
    logic [9:0] res;
    awc_pkg::awc_lim_wr_t lim_wr;
    logic busy;
    logic done;
    logic flag;
    logic [15:0] word;
    int miscompares = 0;
    int n_tests = 0;
    int cyc = 0;

    awc_top #(.SAR_DIV(DIV), .CONV_SAR_CLKS(CLKS)) awc_top_i (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .start_i(start_i),
        .left_justify_select_i(lj),
        .differential_i(diff),
        .result_i(res),
        .lim_wr_i(lim_wr),
        .window_match_flag_clr_i(clr),
        .busy_o(busy),
        .conv_done_o(done),
        .data_word_o(word),
        .window_match_flag_o(flag)
    );

    // ========================================================
    // clock, hang guard and shared tasks
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    // a hang counts as a mismatch and still reaches the verdict
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == LIMIT) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
            miscompares++;
        end
    endtask

    // one byte per write; an idle edge between keeps wr a clean pulse
    task automatic wr(input logic sel, input logic hi, input logic [7:0] d);
        @(posedge core_clk_i);
        #1 lim_wr = '{wr: 1'b1, sel_below: sel, high: hi, data: d};
        @(posedge core_clk_i);
        #1 lim_wr.wr = 1'b0;
    endtask

    task automatic set_lim(input logic [15:0] lt, input logic [15:0] gt);
        wr(1'b1, 1'b1, lt[15:8]);
        wr(1'b1, 1'b0, lt[7:0]);
        wr(1'b0, 1'b1, gt[15:8]);
        wr(1'b0, 1'b0, gt[7:0]);
    endtask

    task automatic clr_flag();
        @(posedge core_clk_i);
        #1 clr = 1'b1;
        @(posedge core_clk_i);
        #1 clr = 1'b0;
        chk("flag cleared", 16'h0000, 16'(flag));
    endtask

    // a stray start while busy must neither stretch nor requeue
    task automatic conv(input logic [9:0] r, input logic l, input logic d,
                        input logic [15:0] ew, input logic ef);
        int n;
        res = r;
        lj = l;
        diff = d;
        start_i = 1'b1;
        @(posedge core_clk_i);
        #1 start_i = 1'b0;
        n = 0;
        chk("busy", 16'h0001, 16'(busy));
        while (done !== 1'b1 && n < 1000) begin
            @(posedge core_clk_i);
            #1 n++;
            start_i = (n == 3);
        end
        chk("latency", 16'(DIV * CLKS), 16'(n));
        chk("busy end", 16'h0000, 16'(busy));
        chk("word", ew, word);
        chk("flag", 16'(ef), 16'(flag));
        @(posedge core_clk_i);
        #1 chk("done pulse", 16'h0000, 16'(done));
        chk("no restart", 16'h0000, 16'(busy));
        chk("flag held", 16'(ef), 16'(flag));
    endtask

    // ========================================================
    // scenarios
    task automatic t_reset();
        chk("reset word", 16'h0000, word);
        chk("reset flag", 16'h0000, 16'(flag));
        conv(10'h001, 1'b0, 1'b0, 16'h0001, 1'b1);
        $display("test reset done");
    endtask

    task automatic t_inside();
        set_lim(16'h0200, 16'h0100);
        clr_flag();
        conv(10'h180, 1'b0, 1'b0, 16'h0180, 1'b1);
        conv(10'h100, 1'b0, 1'b0, 16'h0100, 1'b1);
        clr_flag();
        conv(10'h100, 1'b0, 1'b0, 16'h0100, 1'b0);
        conv(10'h200, 1'b0, 1'b0, 16'h0200, 1'b0);
        conv(10'h1FF, 1'b0, 1'b0, 16'h01FF, 1'b1);
        $display("test inside window done");
    endtask

    task automatic t_outside();
        set_lim(16'h0100, 16'h0200);
        clr_flag();
        conv(10'h201, 1'b0, 1'b0, 16'h0201, 1'b1);
        clr_flag();
        conv(10'h150, 1'b0, 1'b0, 16'h0150, 1'b0);
        conv(10'h200, 1'b0, 1'b0, 16'h0200, 1'b0);
        conv(10'h0FF, 1'b0, 1'b0, 16'h00FF, 1'b1);
        $display("test outside window done");
    endtask

    task automatic t_diff_left();
        set_lim(16'h4000, 16'hFFC0);
        clr_flag();
        conv(10'h000, 1'b1, 1'b1, 16'h0000, 1'b1);
        clr_flag();
        conv(10'h3FF, 1'b1, 1'b1, 16'hFFC0, 1'b0);
        conv(10'h100, 1'b1, 1'b1, 16'h4000, 1'b0);
        conv(10'h0FF, 1'b1, 1'b1, 16'h3FC0, 1'b1);
        set_lim(16'hFFC0, 16'h4000);
        clr_flag();
        conv(10'h200, 1'b1, 1'b1, 16'h8000, 1'b1);
        clr_flag();
        conv(10'h000, 1'b1, 1'b1, 16'h0000, 1'b0);
        conv(10'h101, 1'b1, 1'b1, 16'h4040, 1'b1);
        $display("test differential left done");
    endtask

    // same limits read as signed or unsigned flip the window mode
    task automatic t_right_fmt();
        set_lim(16'h0010, 16'hFFF0);
        clr_flag();
        conv(10'h3FF, 1'b0, 1'b1, 16'hFFFF, 1'b1);
        clr_flag();
        conv(10'h3FF, 1'b0, 1'b0, 16'h03FF, 1'b0);
        conv(10'h001, 1'b1, 1'b0, 16'h0040, 1'b0);
        conv(10'h001, 1'b0, 1'b0, 16'h0001, 1'b1);
        clr_flag();
        conv(10'h200, 1'b0, 1'b1, 16'hFE00, 1'b0);
        $display("test data format done");
    endtask

    // reset held for four cycles, inputs move 1 ns after the edge
    initial begin
        nrst_i = 1'b0;
        start_i = 1'b0;
        lj = 1'b0;
        diff = 1'b0;
        clr = 1'b0;
        res = 10'h000;
        lim_wr = '0;
        repeat (4) @(posedge core_clk_i);
        #1 nrst_i = 1'b1;
        t_reset();
        t_inside();
        t_outside();
        t_diff_left();
        t_right_fmt();
        tally_and_finish();
    end
endmodule // adc_window_comparator_tb_top
`default_nettype wire
